// ===== rtl/ccd_pkg.sv
// constants and types shared by the clear/compare/decrement datapath
package ccd_pkg;
	localparam int DATA_W     = 8;       // datapath width
	localparam int FILE_DEPTH = 64;      // number of file registers
	localparam int FADDR_W    = 6;       // file register address width
	localparam int BUS_AW     = 8;       // register port address width

	// register port map
	localparam logic [7:0] FILE_BASE_OFS = 8'h00; // file registers 0x00..0x3f
	localparam logic [7:0] FILE_LAST_OFS = 8'h3f; // last file register
	localparam logic [7:0] WORK_OFS      = 8'h40; // working register
	localparam logic [7:0] STATUS_OFS    = 8'h41; // status flags
	localparam logic [7:0] CTRL_OFS      = 8'h42; // control bits

	// status field positions
	localparam int ST_ZERO_BIT  = 0;     // zero flag
	localparam int ST_CARRY_BIT = 1;     // carry flag
	localparam int ST_TO_BIT    = 2;     // timeout flag
	localparam int ST_PD_BIT    = 3;     // power-down flag
	// control field positions
	localparam int CT_DIV_WD_BIT = 0;    // shared divider assigned to watchdog

	// reset values
	localparam logic [7:0] WORK_RST   = 8'h00; // working register
	localparam logic [7:0] FILE_RST   = 8'h00; // file registers
	localparam logic [7:0] CLEAR_VAL  = 8'h00; // value written by clears
	localparam logic [7:0] DEC_STEP   = 8'h01; // decrement step
	localparam logic       ZERO_RST   = 1'b0;  // zero flag
	localparam logic       CARRY_RST  = 1'b0;  // carry flag
	localparam logic       TO_RST     = 1'b1;  // timeout flag
	localparam logic       PD_RST     = 1'b1;  // power-down flag
	localparam logic       DIV_WD_RST = 1'b0;  // divider assignment

	// timing: every operation except nop retires in one instruction cycle
	localparam int OP_CYCLES = 1;

	// operation codes
	typedef enum logic [2:0] {
		CCD_NOP       = 3'h0, // no operation
		CCD_CLR_WORK  = 3'h1, // clear_working_op
		CCD_CLR_WDOG  = 3'h2, // clear_watchdog_op
		CCD_CLR_FILE  = 3'h3, // clear_file_op
		CCD_INVERT    = 3'h4, // invert_file_op
		CCD_COMPARE   = 3'h5, // compare_op
		CCD_DECREMENT = 3'h6  // decrement_op
	} ccd_op_t;
endpackage

// ===== rtl/ccd_alu_if.sv
// signals between the sequencer and the combinational operation unit
`timescale 1ns/100ps
interface ccd_alu_if;
	import ccd_pkg::*;
	ccd_op_t            op;         // operation in execution
	logic               dest_file;  // destination select
	logic [DATA_W-1:0]  file_val;   // addressed file register
	logic [DATA_W-1:0]  work_val;   // working register
	logic [DATA_W-1:0]  result;     // computed value
	logic               wr_work;    // result goes to working register
	logic               wr_file;    // result goes to file register
	logic               upd_zero;   // zero flag is updated
	logic               upd_carry;  // carry flag is updated
	logic               zero_val;   // new zero flag
	logic               carry_val;  // new carry flag
	logic               wdog_clr;   // watchdog clear requested

	modport seq (output op, dest_file, file_val, work_val,
		input result, wr_work, wr_file, upd_zero, upd_carry, zero_val, carry_val,
		wdog_clr);
	modport alu (input op, dest_file, file_val, work_val,
		output result, wr_work, wr_file, upd_zero, upd_carry, zero_val, carry_val,
		wdog_clr);
endinterface

// ===== rtl/ccd_alu.sv
// combinational operation unit for the clear/compare/decrement group
`timescale 1ns/100ps
module ccd_alu
	import ccd_pkg::*;
(
	ccd_alu_if.alu a  // operands in, result and flag updates out
);
	logic [DATA_W:0] diff; // file minus subtrahend, with borrow-free bit

	// subtraction shared by compare and decrement
	always_comb begin
		if (a.op == CCD_COMPARE) begin
			diff = {1'b0, a.file_val} + {1'b0, ~a.work_val} + 9'h001; // [RQ8]
		end else begin
			diff = {1'b0, a.file_val} - {1'b0, DEC_STEP}; // [RQ10]
		end
	end

	// per-operation result, destination and flag selection
	always_comb begin
		a.result    = CLEAR_VAL;
		a.wr_work   = 1'b0;
		a.wr_file   = 1'b0;
		a.upd_zero  = 1'b0;
		a.upd_carry = 1'b0;
		a.carry_val = 1'b0;
		a.wdog_clr  = 1'b0;
		case (a.op)
			CCD_CLR_WORK: begin
				a.wr_work  = 1'b1; // [RQ1]
				a.upd_zero = 1'b1;
			end
			CCD_CLR_WDOG: begin
				a.wdog_clr = 1'b1; // [RQ2]
			end
			CCD_CLR_FILE: begin
				a.wr_file  = 1'b1; // [RQ5]
				a.upd_zero = 1'b1;
			end
			CCD_INVERT: begin
				a.result   = ~a.file_val; // [RQ6]
				a.wr_work  = ~a.dest_file; // [RQ7]
				a.wr_file  = a.dest_file;
				a.upd_zero = 1'b1;
			end
			CCD_COMPARE: begin
				a.result    = diff[DATA_W-1:0];
				a.upd_zero  = 1'b1; // result discarded [RQ9]
				a.upd_carry = 1'b1;
				a.carry_val = diff[DATA_W]; // one when no borrow [RQ11]
			end
			CCD_DECREMENT: begin
				a.result   = diff[DATA_W-1:0]; // [RQ10]
				a.wr_work  = ~a.dest_file; // [RQ7]
				a.wr_file  = a.dest_file;
				a.upd_zero = 1'b1;
			end
			default: begin
				a.result = CLEAR_VAL; // nop changes nothing
			end
		endcase
	end

	// zero flag follows the result
	assign a.zero_val = (a.result == CLEAR_VAL); // [RQ1] [RQ5] [RQ11]
endmodule

// ===== rtl/ccd_exec.sv
// clear/compare/decrement execution datapath with file and status registers
// Notes on behaviour
// RQ1 - clear working: working register zero, zero flag set
// RQ2 - clear watchdog resets the watchdog counter
// RQ3 - shared divider cleared only if watchdog-assigned
// RQ4 - clear watchdog sets timeout, power-down; nothing else
// RQ5 - clear file: register zero, zero flag set
// RQ6 - invert: bitwise inverse, only zero flag
// RQ7 - destination bit 0 working, 1 file
// RQ8 - compare: file minus working, two's complement
// RQ9 - compare leaves working and file unchanged
// RQ10 - decrement: file minus one, only zero flag
// RQ11 - compare carry means no borrow; zero equal
// RQ12 - one cycle each, never skips next
`timescale 1ns/100ps
module ccd_exec
	import ccd_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH  // file registers present
)(
	input  wire logic               clk,           // 125 MHz instruction clock
	input  wire logic               srst,          // synchronous reset, active high
	input  wire logic               op_valid,      // operation issued this cycle
	input  wire ccd_op_t            op_code,       // operation to execute
	input  wire logic [FADDR_W-1:0] op_addr,       // file register operand
	input  wire logic               op_dest,       // destination select
	output logic                    op_done,       // operation retired, pulse
	output logic                    op_skip,       // skip next, always low
	output logic                    wdog_clear,    // watchdog counter clear, pulse
	output logic                    div_clear,     // shared divider clear, pulse
	output logic [DATA_W-1:0]       work_out,      // working register
	output logic                    zero_flag,     // zero flag
	output logic                    carry_flag,    // carry flag
	output logic                    timeout_flag,  // timeout flag
	output logic                    power_down_flag, // power-down flag
	input  wire logic [BUS_AW-1:0]  reg_addr,      // register port address
	input  wire logic [DATA_W-1:0]  reg_wdata,     // register port write data
	input  wire logic               reg_wr,        // write strobe
	input  wire logic               reg_rd,        // read strobe
	output logic [DATA_W-1:0]       reg_rdata      // read data, cycle after strobe
);
	// storage
	logic [DATA_W-1:0] file_mem [DEPTH];  // file registers
	logic [DATA_W-1:0] work_reg;          // working register
	logic              zero_reg;          // zero flag
	logic              carry_reg;         // carry flag
	logic              to_reg;            // timeout flag
	logic              pd_reg;            // power-down flag
	logic              div_wd_reg;        // divider assigned to watchdog
	logic              done_reg;          // retire pulse
	logic              wdclr_reg;         // watchdog clear pulse
	logic              divclr_reg;        // divider clear pulse
	logic [DATA_W-1:0] rdata_reg;         // read data
	logic [DATA_W-1:0] rdata_next;        // read data next value

	// decoded strobes
	logic              exec;              // an operation executes now
	logic              bus_file_wr;       // bus writes a file register
	logic [FADDR_W-1:0] bus_file_idx;     // bus file register index
	logic              sw_work_wr;        // bus writes the working register
	logic              sw_status_wr;      // bus writes the status flags
	logic              sw_ctrl_wr;        // bus writes the control bits

	ccd_alu_if alu_bus ();                // link to operation unit

	// true when an address falls in the file register window
	function automatic logic is_file(input logic [BUS_AW-1:0] ad);
		is_file = (ad >= FILE_BASE_OFS) && (ad <= FILE_LAST_OFS)
			&& (32'(ad - FILE_BASE_OFS) < DEPTH);
	endfunction

	// file register index of a bus address
	function automatic logic [FADDR_W-1:0] file_idx(input logic [BUS_AW-1:0] ad);
		logic [BUS_AW-1:0] off;
		off      = ad - FILE_BASE_OFS;
		file_idx = off[FADDR_W-1:0];
	endfunction

	assign exec         = op_valid && (op_code != CCD_NOP);
	assign bus_file_wr  = reg_wr && is_file(reg_addr);
	assign bus_file_idx = file_idx(reg_addr);
	assign sw_work_wr   = reg_wr && (reg_addr == WORK_OFS);
	assign sw_status_wr = reg_wr && (reg_addr == STATUS_OFS);
	assign sw_ctrl_wr   = reg_wr && (reg_addr == CTRL_OFS);

	// operands to the operation unit
	assign alu_bus.op        = exec ? op_code : CCD_NOP;
	assign alu_bus.dest_file = op_dest;
	assign alu_bus.file_val  = file_mem[op_addr];
	assign alu_bus.work_val  = work_reg;

	ccd_alu u_alu (
		.a (alu_bus.alu)
	);

	// file registers; a same-cycle bus write to the operand loses to an operation that writes the file
	// because the operation's write is issued last, other registers still take it
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				file_mem[i] <= FILE_RST;
			end
		end else begin
			if (bus_file_wr) begin
				file_mem[bus_file_idx] <= reg_wdata; // software write
			end
			if (alu_bus.wr_file) begin
				file_mem[op_addr] <= alu_bus.result; // [RQ5] [RQ6] [RQ7] [RQ10]
			end
		end
	end

	// working register
	always_ff @(posedge clk) begin
		if (srst) begin
			work_reg <= WORK_RST;
		end else if (alu_bus.wr_work) begin
			work_reg <= alu_bus.result; // [RQ1] [RQ7]
		end else if (sw_work_wr) begin
			work_reg <= reg_wdata; // software write
		end
	end

	// zero and carry flags: operation update wins over software
	always_ff @(posedge clk) begin
		if (srst) begin
			zero_reg  <= ZERO_RST;
			carry_reg <= CARRY_RST;
		end else begin
			if (alu_bus.upd_zero) begin
				zero_reg <= alu_bus.zero_val; // [RQ1] [RQ5] [RQ6] [RQ10]
			end else if (sw_status_wr) begin
				zero_reg <= reg_wdata[ST_ZERO_BIT];
			end
			if (alu_bus.upd_carry) begin
				carry_reg <= alu_bus.carry_val; // [RQ8] [RQ11]
			end else if (sw_status_wr) begin
				carry_reg <= reg_wdata[ST_CARRY_BIT];
			end
		end
	end

	// timeout and power-down flags: a watchdog clear sets both
	always_ff @(posedge clk) begin
		if (srst) begin
			to_reg <= TO_RST;
			pd_reg <= PD_RST;
		end else if (alu_bus.wdog_clr) begin
			to_reg <= 1'b1; // [RQ4]
			pd_reg <= 1'b1;
		end else if (sw_status_wr) begin
			to_reg <= reg_wdata[ST_TO_BIT];
			pd_reg <= reg_wdata[ST_PD_BIT];
		end
	end

	// divider assignment, written by software
	always_ff @(posedge clk) begin
		if (srst) begin
			div_wd_reg <= DIV_WD_RST;
		end else if (sw_ctrl_wr) begin
			div_wd_reg <= reg_wdata[CT_DIV_WD_BIT];
		end
	end

	// watchdog and divider clear pulses, retire pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			wdclr_reg  <= 1'b0;
			divclr_reg <= 1'b0;
			done_reg   <= 1'b0;
		end else begin
			wdclr_reg  <= alu_bus.wdog_clr; // [RQ2]
			divclr_reg <= alu_bus.wdog_clr && div_wd_reg; // [RQ3]
			done_reg   <= exec; // one cycle per operation [RQ12]
		end
	end

	// read mux for the register port
	always_comb begin
		rdata_next = 8'h00;
		if (!reg_rd) begin
			rdata_next = 8'h00; // data only after a read strobe
		end else if (is_file(reg_addr)) begin
			rdata_next = file_mem[file_idx(reg_addr)];
		end else if (reg_addr == WORK_OFS) begin
			rdata_next = work_reg;
		end else if (reg_addr == STATUS_OFS) begin
			rdata_next[ST_ZERO_BIT]  = zero_reg;
			rdata_next[ST_CARRY_BIT] = carry_reg;
			rdata_next[ST_TO_BIT]    = to_reg;
			rdata_next[ST_PD_BIT]    = pd_reg;
		end else if (reg_addr == CTRL_OFS) begin
			rdata_next[CT_DIV_WD_BIT] = div_wd_reg;
		end else begin
			rdata_next = 8'h00; // unmapped reads zero
		end
	end

	// read data register
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// outputs
	assign op_done         = done_reg;
	assign op_skip         = 1'b0; // no operation here skips [RQ12]
	assign wdog_clear      = wdclr_reg;
	assign div_clear       = divclr_reg;
	assign work_out        = work_reg;
	assign zero_flag       = zero_reg;
	assign carry_flag      = carry_reg;
	assign timeout_flag    = to_reg;
	assign power_down_flag = pd_reg;
	assign reg_rdata       = rdata_reg;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	clear_working_a: assert property ( // [RQ1]
		exec && op_code == CCD_CLR_WORK |=> work_reg == 8'h00 && zero_reg)
		else $error("clear working did not zero register and set zero");

	clear_watchdog_a: assert property ( // [RQ2]
		wdog_clear == ($past(exec && op_code == CCD_CLR_WDOG) && !$past(srst)))
		else $error("watchdog clear pulse wrong");

	divider_gate_a: assert property ( // [RQ3]
		div_clear == ($past(exec && op_code == CCD_CLR_WDOG) && $past(div_wd_reg)
			&& !$past(srst)))
		else $error("divider clear not gated by assignment");

	wdog_status_a: assert property ( // [RQ4]
		exec && op_code == CCD_CLR_WDOG |=> timeout_flag && power_down_flag
			&& $stable(zero_flag) && $stable(carry_flag) && $stable(work_out))
		else $error("watchdog clear status update wrong");

	clear_file_a: assert property ( // [RQ5]
		exec && op_code == CCD_CLR_FILE |=> file_mem[$past(op_addr)] == 8'h00 && zero_reg)
		else $error("clear file did not zero register");

	invert_dest_a: assert property ( // [RQ6]
		exec && op_code == CCD_INVERT && !op_dest
			|=> work_reg == ~$past(alu_bus.file_val) && $stable(carry_reg))
		else $error("invert to working register wrong");

	dest_file_a: assert property ( // [RQ7]
		exec && op_code == CCD_DECREMENT && op_dest |=> $stable(work_reg))
		else $error("file destination touched working register");

	compare_flags_a: assert property ( // [RQ8]
		exec && op_code == CCD_COMPARE
			|=> carry_reg == ($past(alu_bus.file_val) >= $past(work_reg))
			&& zero_reg == ($past(alu_bus.file_val) == $past(work_reg)))
		else $error("compare flags wrong");

	compare_keep_a: assert property ( // [RQ9]
		exec && op_code == CCD_COMPARE && !(reg_wr && reg_addr == WORK_OFS)
			|=> $stable(work_reg))
		else $error("compare changed working register");

	decrement_val_a: assert property ( // [RQ10]
		exec && op_code == CCD_DECREMENT && !op_dest
			|=> work_reg == 8'($past(alu_bus.file_val) - 8'h01) && $stable(carry_reg))
		else $error("decrement result wrong");

	retire_once_a: assert property ( // [RQ12]
		exec |=> op_done && !op_skip)
		else $error("operation did not retire in one cycle");

	idle_retire_a: assert property ( // [RQ12]
		!exec |=> !op_done)
		else $error("retire pulse without an operation");

	invert_file_a: assert property ( // [RQ6] [RQ7]
		exec && op_code == CCD_INVERT && op_dest && !sw_work_wr
			|=> file_mem[$past(op_addr)] == ~$past(alu_bus.file_val) && $stable(work_reg))
		else $error("invert to file register wrong");

	invert_zero_a: assert property ( // [RQ6]
		exec && op_code == CCD_INVERT |=> zero_reg == ($past(alu_bus.file_val) == 8'hff))
		else $error("invert zero flag wrong");

	decrement_file_a: assert property ( // [RQ10]
		exec && op_code == CCD_DECREMENT && op_dest
			|=> file_mem[$past(op_addr)] == 8'($past(alu_bus.file_val) - 8'h01)
			&& $stable(carry_reg))
		else $error("decrement to file register wrong");

	decrement_zero_a: assert property ( // [RQ10]
		exec && op_code == CCD_DECREMENT |=> zero_reg == ($past(alu_bus.file_val) == 8'h01))
		else $error("decrement zero flag wrong");

	compare_file_keep_a: assert property ( // [RQ9]
		exec && op_code == CCD_COMPARE && !bus_file_wr
			|=> file_mem[$past(op_addr)] == $past(alu_bus.file_val))
		else $error("compare changed file register");

	clear_keep_flags_a: assert property ( // [RQ1] [RQ5]
		exec && (op_code == CCD_CLR_WORK || op_code == CCD_CLR_FILE) && !sw_status_wr
			|=> $stable(carry_reg) && $stable(to_reg) && $stable(pd_reg))
		else $error("clear touched flags other than zero");

	wdog_flags_only_a: assert property ( // [RQ4]
		!(exec && op_code == CCD_CLR_WDOG) && !sw_status_wr
			|=> $stable(to_reg) && $stable(pd_reg))
		else $error("timeout or power-down changed without cause");

	// register port checks
	status_write_a: assert property (
		sw_status_wr && !exec
			|=> zero_flag == $past(reg_wdata[ST_ZERO_BIT])
			&& carry_flag == $past(reg_wdata[ST_CARRY_BIT])
			&& timeout_flag == $past(reg_wdata[ST_TO_BIT])
			&& power_down_flag == $past(reg_wdata[ST_PD_BIT]))
		else $error("status write did not land");

	work_write_a: assert property (
		sw_work_wr && !alu_bus.wr_work |=> work_reg == $past(reg_wdata))
		else $error("working register write did not land");

	ctrl_write_a: assert property (
		sw_ctrl_wr |=> div_wd_reg == $past(reg_wdata[CT_DIV_WD_BIT]))
		else $error("control write did not land");

	read_idle_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	read_status_a: assert property (
		reg_rd && reg_addr == STATUS_OFS |=> reg_rdata
			== {4'h0, $past(pd_reg), $past(to_reg), $past(carry_reg), $past(zero_reg)})
		else $error("status read data wrong");

	// coverage of the main scenarios
	compare_equal_c:  cover property (exec && op_code == CCD_COMPARE ##1 zero_reg);
	divider_else_c:   cover property (exec && op_code == CCD_CLR_WDOG && !div_wd_reg);
	decrement_wrap_c: cover property (exec && op_code == CCD_DECREMENT
		&& alu_bus.file_val == 8'h00);
	divider_clear_c:  cover property (div_clear);
	bus_read_c:       cover property (reg_rd && reg_addr == STATUS_OFS);
endmodule

// ===== tb/ccd_exec_bench.sv
// self-checking bench for the clear/compare/decrement execution datapath
`timescale 1ns/100ps
module ccd_exec_bench;
	import ccd_pkg::*;
	typedef struct packed {
		logic [7:0] w;  // working register
		logic       z;  // zero flag
		logic       c;  // carry flag
		logic       to; // timeout flag
		logic       pd; // power-down flag
		logic       wd; // watchdog clear pulse
		logic       dv; // divider clear pulse
	} ccd_exp_t;
	logic                clk = 1'b0;         // 125 MHz clock
	logic                srst = 1'b1;        // synchronous reset
	logic                op_valid = 1'b0;    // operation strobe
	ccd_op_t             op_code = CCD_NOP;  // operation
	logic [FADDR_W-1:0]  op_addr = '0;       // file operand
	logic                op_dest = 1'b0;     // destination select
	logic [BUS_AW-1:0]   reg_addr = '0;      // bus address
	logic [DATA_W-1:0]   reg_wdata = '0;     // bus write data
	logic                reg_wr = 1'b0;      // write strobe
	logic                reg_rd = 1'b0;      // read strobe
	logic                op_done;            // retire pulse
	logic                op_skip;            // skip output
	logic                wdog_clear;         // watchdog clear pulse
	logic                div_clear;          // divider clear pulse
	logic [DATA_W-1:0]   work_out;           // working register
	logic                zero_flag;          // zero flag
	logic                carry_flag;         // carry flag
	logic                timeout_flag;       // timeout flag
	logic                power_down_flag;    // power-down flag
	logic [DATA_W-1:0]   reg_rdata;          // read data
	logic [7:0]          fr [64];            // model file registers
	logic [7:0]          w;                  // model working register
	logic                z, c, to, pd, dw;   // model flags and divider assignment
	ccd_exp_t            oq [$];             // expected operation results
	logic [7:0]          rq [$];             // expected read data
	logic                rd_due = 1'b0;      // read data due this cycle
	logic                op_due = 1'b0;      // retire due this cycle
	int                  miscompares = 0;    // mismatch count
	int                  n_compared = 0;     // comparison count

	// free-running clock
	always #4 clk = ~clk;

	ccd_exec DUT (.clk(clk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
		.op_addr(op_addr), .op_dest(op_dest), .op_done(op_done), .op_skip(op_skip),
		.wdog_clear(wdog_clear), .div_clear(div_clear), .work_out(work_out),
		.zero_flag(zero_flag), .carry_flag(carry_flag), .timeout_flag(timeout_flag),
		.power_down_flag(power_down_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// compare one byte
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// compare operation outcome
	task automatic cmp_op(input ccd_exp_t got, input ccd_exp_t exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: op state got %h want %h", $time, got, exp);
		end
	endtask

	// model back to reset state
	task automatic mreset;
		foreach (fr[i]) fr[i] = 8'h00;
		w = 8'h00;
		{pd, to, c, z} = 4'b1100;
		dw = 1'b0;
	endtask

	// issue one operation and note its outcome
	task automatic op(input ccd_op_t code, input logic [5:0] a, input logic d);
		logic [7:0] r;
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= code;
		op_addr <= a;
		op_dest <= d;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		case (code)
			CCD_CLR_WORK: begin
				w = 8'h00;
				z = 1'b1;
			end
			CCD_CLR_WDOG: {to, pd} = 2'b11;
			CCD_CLR_FILE: begin
				fr[a] = 8'h00;
				z = 1'b1;
			end
			CCD_INVERT, CCD_DECREMENT: begin
				r = (code == CCD_INVERT) ? ~fr[a] : fr[a] - 8'h01;
				z = (r == 8'h00);
				if (d) fr[a] = r;
				else w = r;
			end
			CCD_COMPARE: begin
				z = (fr[a] == w);
				c = (fr[a] >= w);
			end
			default: ;
		endcase
		if (code != CCD_NOP) oq.push_back({w, z, c, to, pd, code == CCD_CLR_WDOG,
			code == CCD_CLR_WDOG && dw});
	endtask

	// one bus write or read
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] dat);
		@(posedge clk);
		op_valid <= 1'b0;
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= dat;
		if (wr) begin
			if (a <= FILE_LAST_OFS) fr[a[5:0]] = dat;
			else if (a == WORK_OFS) w = dat;
			else if (a == STATUS_OFS) {pd, to, c, z} = dat[3:0];
			else if (a == CTRL_OFS) dw = dat[0];
		end else begin
			rq.push_back(a <= FILE_LAST_OFS ? fr[a[5:0]] : a == WORK_OFS ? w :
				a == STATUS_OFS ? {4'h0, pd, to, c, z} : a == CTRL_OFS ? {7'h00, dw} : 8'h00);
		end
	endtask

	// one quiet cycle
	task automatic idle;
		@(posedge clk);
		op_valid <= 1'b0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask

	// value with corner cases favoured
	function automatic logic [7:0] pick;
		case ($urandom_range(0, 3))
			0: pick = 8'h00;
			1: pick = 8'h01;
			2: pick = 8'hff;
			default: pick = 8'($urandom);
		endcase
	endfunction

	// print counts and verdict, then stop
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// watcher: takes the oldest note whenever a result is due
	always @(negedge clk) begin
		cmp8({7'h00, op_skip}, 8'h00, "skip");
		if (rd_due) begin
			if (rq.size() == 0) cmp8(8'h00, 8'h01, "read queue empty");
			else cmp8(reg_rdata, rq.pop_front(), "read data");
		end else begin
			cmp8(reg_rdata, 8'h00, "idle read data");
		end
		if (op_due) begin
			cmp8({7'h00, op_done}, 8'h01, "done");
			if (oq.size() != 0) cmp_op({work_out, zero_flag, carry_flag, timeout_flag,
				power_down_flag, wdog_clear, div_clear}, oq.pop_front());
		end else begin
			cmp8({5'h00, op_done, wdog_clear, div_clear}, 8'h00, "stray pulse");
		end
		rd_due = reg_rd;
		op_due = op_valid && op_code != CCD_NOP;
	end

	// main sequence
	initial begin
		int i;
		logic [3:0] sel;
		logic [5:0] a;
		i = $urandom(62691);
		mreset();
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// reset values
		foreach (fr[k]) if (k < 4) bus(1'b0, WORK_OFS + 8'(k), 8'h00);
		bus(1'b0, FILE_LAST_OFS, 8'h00);
		// decrement 1 to 0 and 0 wraps to ff, both destinations
		bus(1'b1, 8'h05, 8'h01);
		op(CCD_DECREMENT, 6'h05, 1'b1);
		op(CCD_DECREMENT, 6'h05, 1'b0);
		bus(1'b0, 8'h05, 8'h00);
		// compare below, equal and above the working register
		bus(1'b1, WORK_OFS, 8'h34);
		for (i = 0; i < 3; i++) begin
			bus(1'b1, 8'h07, 8'h33 + 8'(i));
			op(CCD_COMPARE, 6'h07, 1'b1);
			bus(1'b0, 8'h07, 8'h00);
		end
		// invert to zero, then clears back to back
		bus(1'b1, 8'h09, 8'hff);
		op(CCD_INVERT, 6'h09, 1'b1);
		op(CCD_CLR_FILE, 6'h09, 1'b0);
		op(CCD_CLR_WORK, 6'h00, 1'b0);
		// watchdog clear with divider assigned elsewhere, then to watchdog
		for (i = 0; i < 2; i++) begin
			bus(1'b1, CTRL_OFS, 8'(i));
			bus(1'b1, STATUS_OFS, 8'h03);
			op(CCD_CLR_WDOG, 6'h00, 1'b0);
			bus(1'b0, STATUS_OFS, 8'h00);
		end
		// random mix of operations and bus traffic, unmapped place included
		repeat (600) begin
			sel = 4'($urandom_range(0, 9));
			a = 6'($urandom_range(0, 63));
			if (sel < 4'd7) op(ccd_op_t'(sel[2:0]), a, 1'($urandom_range(0, 1)));
			else if (sel == 4'd9) idle();
			else case ($urandom_range(0, 4))
				0: bus(sel == 4'd7, {2'b00, a}, pick());
				1: bus(sel == 4'd7, WORK_OFS, pick());
				2: bus(sel == 4'd7, STATUS_OFS, pick());
				3: bus(sel == 4'd7, CTRL_OFS, pick());
				default: bus(sel == 4'd7, 8'h80 + {2'b00, a}, pick());
			endcase
		end
		// reset in mid-run
		idle();
		idle();
		@(posedge clk);
		srst <= 1'b1;
		mreset();
		@(posedge clk);
		srst <= 1'b0;
		bus(1'b0, STATUS_OFS, 8'h00);
		bus(1'b0, 8'h05, 8'h00);
		op(CCD_COMPARE, 6'h05, 1'b0);
		idle();
		// bounded drain of outstanding notes
		i = 0;
		while ((oq.size() != 0 || rq.size() != 0) && i < 20) begin
			@(posedge clk);
			i++;
		end
		if (i == 20) cmp8(8'h00, 8'h01, "results never appeared");
		final_report();
	end
endmodule
